// file: src/mft_pkg.sv
// package of register map, field positions and codes for the multifunction timer
`default_nettype none
package mft_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_CNT1 = 8'h00;
  localparam logic [7:0] OFF_CRA = 8'h04;
  localparam logic [7:0] OFF_CRB = 8'h08;
  localparam logic [7:0] OFF_CNT2 = 8'h0c;
  localparam logic [7:0] OFF_PRSC = 8'h10;
  localparam logic [7:0] OFF_CKC = 8'h14;
  localparam logic [7:0] OFF_MCTRL = 8'h18;
  localparam logic [7:0] OFF_ICTRL = 8'h1c;
  localparam logic [7:0] OFF_ICLR = 8'h20;
  // reset values
  localparam logic [15:0] RST_16 = 16'h0000;
  localparam logic [7:0] RST_8 = 8'h00;
  localparam logic [5:0] RST_CKC = 6'h00;
  localparam logic [10:0] RST_MCTRL = 11'h000;
  // clock source control fields
  localparam int CKC_C1_LSB = 0;
  localparam int CKC_C2_LSB = 3;
  // mode control field positions
  localparam int MC_MODE_LSB = 0;
  localparam int MC_AEDG = 2;
  localparam int MC_BEDG = 3;
  localparam int MC_AEN = 4;
  localparam int MC_BEN = 5;
  localparam int MC_AOUT = 6;
  localparam int MC_EN = 7;
  localparam int MC_PTEN = 8;
  localparam int MC_PTSE = 9;
  localparam int MC_PTET = 10;
  // irq control field positions
  localparam int IC_PND_LSB = 0;
  localparam int IC_IEN_LSB = 4;
  // pending flag indices
  localparam int PND_A = 0;
  localparam int PND_B = 1;
  localparam int PND_C = 2;
  localparam int PND_D = 3;
  // clock source codes
  typedef enum logic [2:0] {
    SRC_STOP = 3'b000,
    SRC_PRESCALED = 3'b001,
    SRC_EXT_EVENT = 3'b010,
    SRC_PULSE_ACC = 3'b011,
    SRC_LOW_SPEED = 3'b100
  } mft_src_e;
  // operating modes
  typedef enum logic [1:0] {
    MODE_PWM = 2'b00,
    MODE_DUAL_CAPTURE = 2'b01,
    MODE_DUAL_COUNTER = 2'b10,
    MODE_CAPTURE_TIMER = 2'b11
  } mft_mode_e;
endpackage
`default_nettype wire

// file: src/mft_regs.sv
// register file and event sources of one multifunction timer instance
// Functional notes
// - counter one value: low 16 bits, read/write
// - counter one source: stop, prescaled, event, accumulate, slow
// - counter two source at bits 5:3, same codes
// - event and accumulate sources only in modes 1, 3
// - two-bit operating mode field selects four modes
// - pin A edge: 0 falling, 1 rising
// - pin B edge: 0 falling, 1 rising
// - separate enables for pin A and pin B
// - output-data bit gives pin A level
// - global enable switches the instance on
// - pulse-train select only effective in mode 00
// - software trigger starts pulse train; zero ignored
// - event flag set on pulse-train event trigger
// - four read-only pending flags in bits 3:0
// - four enables in bits 7:4 gate pending flags
// - writing one to clear register clears flag
// - flags A-C drive line one, D line two
// - output bit sets initial and present PWM level
`default_nettype none
module mft_regs (
  // clock and reset
  input wire logic mclk_in,
  input wire logic resetn_in,
  // register port
  input wire logic [7:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [31:0] rdata_out,
  // pins and event sources
  input wire logic timer_pin_a_in,
  input wire logic timer_pin_b_in,
  input wire logic low_speed_tick_in,
  input wire logic [3:0] pending_set_in,
  input wire logic pulse_train_event_in,
  // outputs
  output logic timer_pin_a_out,
  output logic timer_pin_a_oe_n_out,
  output logic pin_a_edge_out,
  output logic pin_b_edge_out,
  output logic counter_one_tick_out,
  output logic counter_two_tick_out,
  output logic pulse_train_start_out,
  output logic pulse_train_active_out,
  output logic timer_irq_line_one_out,
  output logic timer_irq_line_two_out
);
  logic [15:0] cnt1_reg, cnt1_next, cra_reg, cra_next, crb_reg, crb_next, cnt2_reg, cnt2_next;
  logic [7:0] prsc_reg, prsc_next, pdiv_reg, pdiv_next;
  logic [5:0] ckc_reg, ckc_next;
  logic [10:0] mc_reg, mc_next;
  logic [3:0] pnd_reg, pnd_next, ien_reg, ien_next;
  logic [31:0] rdata_reg, rdata_next;
  logic ptse_reg, ptse_next;
  logic [1:0] a_sync_reg, b_sync_reg;
  logic a_prev_reg, b_prev_reg, ev_a_reg, ev_b_reg;
  logic pre_tick;
  logic ev_a, ev_b;
  logic [1:0] mode;
  logic mode_ok_ext;
  // two-stage synchronisers, first stage read only by second
  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      a_sync_reg <= 2'h0;
      b_sync_reg <= 2'h0;
      a_prev_reg <= 1'b0;
      b_prev_reg <= 1'b0;
    end else begin
      a_sync_reg <= {a_sync_reg[0], timer_pin_a_in};
      b_sync_reg <= {b_sync_reg[0], timer_pin_b_in};
      a_prev_reg <= a_sync_reg[1];
      b_prev_reg <= b_sync_reg[1];
    end
  end
  // selected-edge detect per pin
  always_comb begin
    ev_a = mc_reg[mft_pkg::MC_AEDG] ? (a_sync_reg[1] & ~a_prev_reg) : (~a_sync_reg[1] & a_prev_reg);
    ev_b = mc_reg[mft_pkg::MC_BEDG] ? (b_sync_reg[1] & ~b_prev_reg) : (~b_sync_reg[1] & b_prev_reg);
  end
  // registered edge events, gated by pin enables
  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      ev_a_reg <= 1'b0;
      ev_b_reg <= 1'b0;
    end else begin
      ev_a_reg <= ev_a & mc_reg[mft_pkg::MC_AEN];
      ev_b_reg <= ev_b & mc_reg[mft_pkg::MC_BEN];
    end
  end
  assign pin_a_edge_out = ev_a_reg;
  assign pin_b_edge_out = ev_b_reg;
  assign mode = mc_reg[mft_pkg::MC_MODE_LSB +: 2];
  // external sources only legal in PWM mode 00 and dual counter mode 10
  assign mode_ok_ext = (mode == mft_pkg::MODE_PWM) || (mode == mft_pkg::MODE_DUAL_COUNTER);
  // prescaler divides system clock by value plus one
  always_comb begin
    pdiv_next = pdiv_reg;
    pre_tick = 1'b0;
    if (!mc_reg[mft_pkg::MC_EN]) begin
      pdiv_next = mft_pkg::RST_8;
    end else if (pdiv_reg >= prsc_reg) begin
      pdiv_next = mft_pkg::RST_8;
      pre_tick = 1'b1;
    end else begin
      pdiv_next = pdiv_reg + 8'h01;
    end
  end
  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      pdiv_reg <= mft_pkg::RST_8;
    end else begin
      pdiv_reg <= pdiv_next;
    end
  end
  // source select per counter; disabled instance gives no ticks
  function automatic logic src_tick(input logic [2:0] sel, input logic pre, input logic ls, input logic ev,
                                    input logic okx, input logic bpin);
    logic t;
    t = 1'b0;
    case (sel)
      mft_pkg::SRC_PRESCALED: t = pre;
      mft_pkg::SRC_EXT_EVENT: t = okx & ev;
      mft_pkg::SRC_PULSE_ACC: t = okx & bpin & pre;
      mft_pkg::SRC_LOW_SPEED: t = ls;
      default: t = 1'b0;
    endcase
    return t;
  endfunction
  always_comb begin
    counter_one_tick_out = mc_reg[mft_pkg::MC_EN] & src_tick(ckc_reg[mft_pkg::CKC_C1_LSB +: 3], pre_tick,
      low_speed_tick_in, ev_b_reg, mode_ok_ext, b_sync_reg[1]);
    counter_two_tick_out = mc_reg[mft_pkg::MC_EN] & src_tick(ckc_reg[mft_pkg::CKC_C2_LSB +: 3], pre_tick,
      low_speed_tick_in, ev_b_reg, mode_ok_ext, b_sync_reg[1]);
  end
  // pulse train active only with mode 00
  assign pulse_train_active_out = mc_reg[mft_pkg::MC_PTEN] && (mode == mft_pkg::MODE_PWM);
  assign pulse_train_start_out = ptse_reg;
  // pin A output level follows the output-data bit
  assign timer_pin_a_out = mc_reg[mft_pkg::MC_AOUT];
  assign timer_pin_a_oe_n_out = ~(mc_reg[mft_pkg::MC_AEN] & (mode != mft_pkg::MODE_DUAL_CAPTURE));
  // interrupt lines from enabled pending flags
  assign timer_irq_line_one_out = |(pnd_reg[2:0] & ien_reg[2:0]);
  assign timer_irq_line_two_out = pnd_reg[mft_pkg::PND_D] & ien_reg[mft_pkg::PND_D];
  assign rdata_out = rdata_reg;
  // register writes, flag updates and read mux
  always_comb begin
    cnt1_next = cnt1_reg;
    cra_next = cra_reg;
    crb_next = crb_reg;
    cnt2_next = cnt2_reg;
    prsc_next = prsc_reg;
    ckc_next = ckc_reg;
    mc_next = mc_reg;
    ien_next = ien_reg;
    ptse_next = 1'b0;
    rdata_next = 32'h00000000;
    pnd_next = pnd_reg;
    if (wr_in) begin
      case (addr_in)
        mft_pkg::OFF_CNT1: cnt1_next = wdata_in[15:0];
        mft_pkg::OFF_CRA: cra_next = wdata_in[15:0];
        mft_pkg::OFF_CRB: crb_next = wdata_in[15:0];
        mft_pkg::OFF_CNT2: cnt2_next = wdata_in[15:0];
        mft_pkg::OFF_PRSC: prsc_next = wdata_in[7:0];
        mft_pkg::OFF_CKC: ckc_next = wdata_in[5:0];
        mft_pkg::OFF_MCTRL: begin
          // event flag is hardware-owned; software write of zero clears it
          mc_next = {wdata_in[10] & mc_reg[mft_pkg::MC_PTET], 1'b0, wdata_in[8:0]};
          ptse_next = wdata_in[mft_pkg::MC_PTSE] & pulse_train_active_out;
        end
        mft_pkg::OFF_ICTRL: ien_next = wdata_in[mft_pkg::IC_IEN_LSB +: 4];
        mft_pkg::OFF_ICLR: pnd_next = pnd_reg & ~wdata_in[3:0];
        default: ;
      endcase
    end
    // hardware set wins over a same-cycle clear
    pnd_next = pnd_next | pending_set_in;
    if (pulse_train_event_in && pulse_train_active_out) begin
      mc_next[mft_pkg::MC_PTET] = 1'b1;
    end
    if (rd_in) begin
      case (addr_in)
        mft_pkg::OFF_CNT1: rdata_next = {16'h0000, cnt1_reg};
        mft_pkg::OFF_CRA: rdata_next = {16'h0000, cra_reg};
        mft_pkg::OFF_CRB: rdata_next = {16'h0000, crb_reg};
        mft_pkg::OFF_CNT2: rdata_next = {16'h0000, cnt2_reg};
        mft_pkg::OFF_PRSC: rdata_next = {24'h000000, prsc_reg};
        mft_pkg::OFF_CKC: rdata_next = {26'h0000000, ckc_reg};
        mft_pkg::OFF_MCTRL: rdata_next = {21'h000000, mc_reg};
        mft_pkg::OFF_ICTRL: rdata_next = {24'h000000, ien_reg, pnd_reg};
        default: rdata_next = 32'h00000000;
      endcase
    end
  end
  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      cnt1_reg <= mft_pkg::RST_16;
      cra_reg <= mft_pkg::RST_16;
      crb_reg <= mft_pkg::RST_16;
      cnt2_reg <= mft_pkg::RST_16;
      prsc_reg <= mft_pkg::RST_8;
      ckc_reg <= mft_pkg::RST_CKC;
      mc_reg <= mft_pkg::RST_MCTRL;
      ien_reg <= 4'h0;
      pnd_reg <= 4'h0;
      ptse_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
    end else begin
      cnt1_reg <= cnt1_next;
      cra_reg <= cra_next;
      crb_reg <= crb_next;
      cnt2_reg <= cnt2_next;
      prsc_reg <= prsc_next;
      ckc_reg <= ckc_next;
      mc_reg <= mc_next;
      ien_reg <= ien_next;
      pnd_reg <= pnd_next;
      ptse_reg <= ptse_next;
      rdata_reg <= rdata_next;
    end
  end
  // assertions
  sequence s_clr_a;
    wr_in && addr_in == mft_pkg::OFF_ICLR && wdata_in[0] && !pending_set_in[0];
  endsequence
  AST_CLEAR_A: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    s_clr_a |=> !pnd_reg[0]) else $error("flag a not cleared");
  AST_SET_WINS: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    pending_set_in[3] |=> pnd_reg[3]) else $error("flag d set lost");
  AST_LINE_ONE: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    timer_irq_line_one_out == |(pnd_reg[2:0] & ien_reg[2:0])) else $error("line one wrong");
  AST_LINE_TWO: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    (pnd_reg[3] && ien_reg[3]) |-> timer_irq_line_two_out) else $error("line two missing");
  AST_CNT1_RW: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    (wr_in && addr_in == mft_pkg::OFF_CNT1) ##1 (rd_in && addr_in == mft_pkg::OFF_CNT1)
    |=> rdata_out == {16'h0000, $past(wdata_in[15:0], 2)}) else $error("counter one readback");
  // divide-by-three spacing, only while no write can move the divider
  sequence s_pre_div3;
    pre_tick && mc_reg[mft_pkg::MC_EN] && prsc_reg == 8'h02 && !wr_in;
  endsequence
  AST_PRE_GAP1: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    s_pre_div3 |=> !pre_tick) else $error("prescale tick too soon");
  AST_PRE_GAP2: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    s_pre_div3 ##1 !wr_in |=> !pre_tick) else $error("prescale tick second gap");
  AST_PRE_FULL: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    (mc_reg[mft_pkg::MC_EN] && prsc_reg == 8'h00) |-> pre_tick) else $error("prescale full rate");
  AST_STOPPED: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    (ckc_reg[2:0] == 3'b000 || !mc_reg[mft_pkg::MC_EN]) |-> !counter_one_tick_out) else $error("stopped ticks");
  AST_EXT_MODE: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    (ckc_reg[5:3] == 3'b010 && !mode_ok_ext) |-> !counter_two_tick_out) else $error("ext source bad mode");
  AST_PTSE: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    (wr_in && addr_in == mft_pkg::OFF_MCTRL && !wdata_in[9]) |=> !pulse_train_start_out) else $error("trigger");
  AST_PTEN: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    (mode != 2'b00) |-> !pulse_train_active_out) else $error("pulse train outside mode");
  // divider parks at zero while the instance is off
  AST_PRE_OFF: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    !mc_reg[mft_pkg::MC_EN] |=> pdiv_reg == mft_pkg::RST_8) else $error("divider not parked");
  // disabled pins never report an edge
  AST_EV_A_OFF: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    !mc_reg[mft_pkg::MC_AEN] |=> !pin_a_edge_out) else $error("pin a edge while off");
  // same for pin B
  AST_EV_B_OFF: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    !mc_reg[mft_pkg::MC_BEN] |=> !pin_b_edge_out) else $error("pin b edge while off");
  // rising edge on A reported one cycle after it is seen synchronised
  AST_RISE_A: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    (mc_reg[mft_pkg::MC_AEDG] && mc_reg[mft_pkg::MC_AEN] && a_sync_reg[1] && !a_prev_reg) |=> pin_a_edge_out)
    else $error("pin a rise lost");
  // falling edge on A when polarity bit clear
  AST_FALL_A: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    (!mc_reg[mft_pkg::MC_AEDG] && mc_reg[mft_pkg::MC_AEN] && !a_sync_reg[1] && a_prev_reg) |=> pin_a_edge_out)
    else $error("pin a fall lost");
  // rising edge on B
  AST_RISE_B: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    (mc_reg[mft_pkg::MC_BEDG] && mc_reg[mft_pkg::MC_BEN] && b_sync_reg[1] && !b_prev_reg) |=> pin_b_edge_out)
    else $error("pin b rise lost");
  // falling edge on B
  AST_FALL_B: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    (!mc_reg[mft_pkg::MC_BEDG] && mc_reg[mft_pkg::MC_BEN] && !b_sync_reg[1] && b_prev_reg) |=> pin_b_edge_out)
    else $error("pin b fall lost");
  // the unselected edge stays quiet
  AST_WRONG_EDGE_A: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    (mc_reg[mft_pkg::MC_AEDG] && !a_sync_reg[1] && a_prev_reg) |=> !pin_a_edge_out) else $error("pin a wrong edge");
  // slow clock source passes the slow tick through
  AST_LOW_SPEED: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    (mc_reg[mft_pkg::MC_EN] && ckc_reg[2:0] == 3'b100) |-> counter_one_tick_out == low_speed_tick_in)
    else $error("slow source one");
  // prescaled source follows the divider tick
  AST_C1_PRE: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    (mc_reg[mft_pkg::MC_EN] && ckc_reg[2:0] == 3'b001) |-> counter_one_tick_out == pre_tick)
    else $error("prescaled source one");
  // counter two stopped by code zero or by the global enable
  AST_C2_STOP: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    (ckc_reg[5:3] == 3'b000 || !mc_reg[mft_pkg::MC_EN]) |-> !counter_two_tick_out) else $error("two stopped ticks");
  // counter two slow source
  AST_C2_SLOW: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    (mc_reg[mft_pkg::MC_EN] && ckc_reg[5:3] == 3'b100) |-> counter_two_tick_out == low_speed_tick_in)
    else $error("slow source two");
  // accumulate refused outside PWM and dual counter modes
  AST_ACC_MODE: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    (ckc_reg[2:0] == 3'b011 && !mode_ok_ext) |-> !counter_one_tick_out) else $error("accumulate bad mode");
  // a set trigger bit in mode 1a gives one start pulse
  AST_PTSE_START: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    (wr_in && addr_in == mft_pkg::OFF_MCTRL && wdata_in[9] && pulse_train_active_out) |=> pulse_train_start_out)
    else $error("trigger lost");
  // event in mode 1a sets the flag
  AST_PTET_SET: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    (pulse_train_event_in && pulse_train_active_out) |=> mc_reg[mft_pkg::MC_PTET]) else $error("event flag lost");
  // software can never set the event flag
  AST_PTET_HOLD: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    (!mc_reg[mft_pkg::MC_PTET] && !(pulse_train_event_in && pulse_train_active_out)) |=> !mc_reg[mft_pkg::MC_PTET])
    else $error("event flag set falsely");
  // pin level takes the written output-data bit
  AST_PIN_LEVEL: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    (wr_in && addr_in == mft_pkg::OFF_MCTRL) |=> timer_pin_a_out == $past(wdata_in[6])) else $error("pin a level");
  // mode field takes the written code
  AST_MODE_WRITE: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    (wr_in && addr_in == mft_pkg::OFF_MCTRL) |=> mode == $past(wdata_in[1:0])) else $error("mode write");
  // interrupt enables take bits 7:4
  AST_IEN_WRITE: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    (wr_in && addr_in == mft_pkg::OFF_ICTRL) |=> ien_reg == $past(wdata_in[7:4])) else $error("enable write");
  // plain storage registers
  AST_PRSC_WRITE: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    (wr_in && addr_in == mft_pkg::OFF_PRSC) |=> prsc_reg == $past(wdata_in[7:0])) else $error("prescaler write");
  // source fields
  AST_CKC_WRITE: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    (wr_in && addr_in == mft_pkg::OFF_CKC) |=> ckc_reg == $past(wdata_in[5:0])) else $error("source write");
  // counter two storage
  AST_CNT2_WRITE: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    (wr_in && addr_in == mft_pkg::OFF_CNT2) |=> cnt2_reg == $past(wdata_in[15:0])) else $error("counter two write");
  // capture/reload A storage
  AST_CRA_WRITE: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    (wr_in && addr_in == mft_pkg::OFF_CRA) |=> cra_reg == $past(wdata_in[15:0])) else $error("reload a write");
  // capture/reload B storage
  AST_CRB_WRITE: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    (wr_in && addr_in == mft_pkg::OFF_CRB) |=> crb_reg == $past(wdata_in[15:0])) else $error("reload b write");
  // read data stand only in the cycle after the strobe
  AST_RD_IDLE: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    !rd_in |=> rdata_out == 32'h00000000) else $error("read data outside slot");
  // clear register is write-only
  AST_CLR_READ: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    (rd_in && addr_in == mft_pkg::OFF_ICLR) |=> rdata_out == 32'h00000000) else $error("clear register read");
  // holes above the map read zero
  AST_UNMAPPED: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    (rd_in && addr_in > mft_pkg::OFF_ICLR) |=> rdata_out == 32'h00000000) else $error("unmapped read");
  // pin A is an input in dual capture, never driven
  AST_OE_CAPTURE: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    (mode == mft_pkg::MODE_DUAL_CAPTURE) |-> timer_pin_a_oe_n_out) else $error("pin a driven in capture");
  // a flag holds unless set or cleared
  AST_PND_HOLD_B: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    (!pending_set_in[1] && !(wr_in && addr_in == mft_pkg::OFF_ICLR && wdata_in[1])) |=> pnd_reg[1] == $past(pnd_reg[1]))
    else $error("flag b moved");
  // line two needs its enable
  AST_LINE_TWO_OFF: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    !ien_reg[3] |-> !timer_irq_line_two_out) else $error("line two without enable");
  // flag D never reaches line one
  AST_LINE_ONE_D: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    (pnd_reg[2:0] == 3'h0) |-> !timer_irq_line_one_out) else $error("line one from flag d");
endmodule
`default_nettype wire

// file: verif/multifunction_timer_regs_bench.sv
// self-checking bench for the multifunction timer register block
`default_nettype none
module multifunction_timer_regs_bench;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [7:0] a; logic [31:0] w; logic [31:0] e;} mft_row_s;
  logic mclk_in = 1'b0, resetn_in = 1'b0, wr = 1'b0, rd = 1'b0, pin_a = 1'b0, pin_b = 1'b0;
  logic ls_tick = 1'b0, pt_ev = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0] pset = 4'h0;
  logic a_out, a_oe_n, a_edge, b_edge, tick1, tick2, pt_start, pt_act, irq1, irq2;
  int n_mismatch = 0, checked = 0, c;
  mft_row_s rows[10];
  mft_regs i_mft_regs (.mclk_in(mclk_in), .resetn_in(resetn_in), .addr_in(addr), .wdata_in(wdata),
    .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .timer_pin_a_in(pin_a), .timer_pin_b_in(pin_b),
    .low_speed_tick_in(ls_tick), .pending_set_in(pset), .pulse_train_event_in(pt_ev),
    .timer_pin_a_out(a_out), .timer_pin_a_oe_n_out(a_oe_n), .pin_a_edge_out(a_edge),
    .pin_b_edge_out(b_edge), .counter_one_tick_out(tick1), .counter_two_tick_out(tick2),
    .pulse_train_start_out(pt_start), .pulse_train_active_out(pt_act),
    .timer_irq_line_one_out(irq1), .timer_irq_line_two_out(irq2));
  // 100 MHz system clock
  initial begin
    forever #5 mclk_in = ~mclk_in;
  end
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      n_mismatch++;
    end
  endtask
  // one-cycle write strobe, released on the edge that takes it
  task wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_in);
    wr <= 1'b1; addr <= a; wdata <= d;
    @(posedge mclk_in);
    wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task rd_chk(input string nm, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge mclk_in);
    rd <= 1'b1; addr <= a;
    @(posedge mclk_in);
    rd <= 1'b0;
    #1 chk(nm, e, rdata & m);
  endtask
  // counts pulses on one output over n cycles, first sample just after the current edge
  task cnt(input int sel, input int n, output int k);
    k = 0;
    repeat (n) begin
      #1;
      case (sel)
        0: k += (tick1 === 1'b1);
        1: k += (tick2 === 1'b1);
        2: k += (a_edge === 1'b1);
        3: k += (b_edge === 1'b1);
        default: k += (pt_start === 1'b1);
      endcase
      @(posedge mclk_in);
    end
  endtask
  task finish_test;
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    rows = '{'{8'h00, 32'hffff, 32'hffff}, '{8'h04, 32'habcd, 32'habcd}, '{8'h08, 32'h5a5a, 32'h5a5a},
      '{8'h0c, 32'hffff, 32'hffff}, '{8'h10, 32'hff, 32'hff}, '{8'h14, 32'h24, 32'h24},
      '{8'h18, 32'hfd, 32'hfd}, '{8'h1c, 32'hff, 32'hf0}, '{8'h20, 32'h0, 32'h0}, '{8'h24, 32'h1, 32'h0}};
    repeat (3) @(posedge mclk_in);
    resetn_in <= 1'b1;
    // ordinary register rows: write then read back
    foreach (rows[i]) begin
      wr_reg(rows[i].a, rows[i].w);
      rd_chk("reg", rows[i].a, 32'hffffffff, rows[i].e);
    end
    // back-to-back write and read of counter one, no idle cycle
    @(posedge mclk_in);
    wr <= 1'b1;
    addr <= 8'h00;
    wdata <= 32'h1234;
    @(posedge mclk_in);
    wr <= 1'b0;
    rd <= 1'b1;
    @(posedge mclk_in);
    rd <= 1'b0;
    #1 chk("b2b", 32'h1234, rdata);
    $display("register rows done");
    // synchronous reset brings every register back to zero
    @(posedge mclk_in);
    resetn_in <= 1'b0;
    repeat (3) @(posedge mclk_in);
    resetn_in <= 1'b1;
    foreach (rows[i]) rd_chk("reset", rows[i].a, 32'hffffffff, 32'h0);
    chk("oe_n", 1'b1, a_oe_n);
    $display("reset done");
    // pending flags, enables, clears and line routing
    wr_reg(8'h1c, 32'h50);
    @(posedge mclk_in);
    pset <= 4'hf;
    @(posedge mclk_in);
    pset <= 4'h0;
    rd_chk("ictrl", 8'h1c, 32'hff, 32'h5f);
    chk("irq1", 1'b1, irq1);
    chk("irq2", 1'b0, irq2);
    wr_reg(8'h20, 32'h1);
    #1 chk("irq1", 1'b1, irq1);
    wr_reg(8'h20, 32'h4);
    #1 chk("irq1", 1'b0, irq1);
    wr_reg(8'h1c, 32'h80);
    #1 chk("irq2", 1'b1, irq2);
    @(posedge mclk_in);
    wr <= 1'b1; addr <= 8'h20; wdata <= 32'h8; pset <= 4'h8;
    @(posedge mclk_in);
    wr <= 1'b0; pset <= 4'h0;
    rd_chk("set_wins", 8'h1c, 32'hff, 32'h8a);
    wr_reg(8'h20, 32'hf);
    rd_chk("clr_all", 8'h1c, 32'hff, 32'h80);
    #1 chk("irq2", 1'b0, irq2);
    $display("interrupt flags done");
    // pin A level and drive enable
    wr_reg(8'h18, 32'h50);
    #1 chk("a_out", 1'b1, a_out);
    chk("oe_n", 1'b0, a_oe_n);
    wr_reg(8'h18, 32'h51);
    #1 chk("oe_n", 1'b1, a_oe_n);
    wr_reg(8'h18, 32'h40);
    #1 chk("oe_n", 1'b1, a_oe_n);
    wr_reg(8'h18, 32'h10);
    #1 chk("a_out", 1'b0, a_out);
    $display("pin a done");
    // count sources: slow clock, prescaler, gated by the global enable
    ls_tick <= 1'b1;
    wr_reg(8'h14, 32'h24);
    wr_reg(8'h18, 32'h80);
    cnt(0, 5, c); chk("slow1", 5, c);
    cnt(1, 5, c); chk("slow2", 5, c);
    wr_reg(8'h18, 32'h00);
    cnt(0, 5, c); chk("off", 0, c);
    wr_reg(8'h10, 32'h2);
    wr_reg(8'h14, 32'h09);
    wr_reg(8'h18, 32'h80);
    cnt(0, 30, c); chk("presc", 10, c);
    wr_reg(8'h14, 32'h00);
    cnt(0, 5, c); chk("stop", 0, c);
    // pulse accumulate refused in mode 01, allowed in mode 00
    pin_b <= 1'b1;
    wr_reg(8'h10, 32'h0);
    wr_reg(8'h14, 32'h1b);
    wr_reg(8'h18, 32'h81);
    cnt(0, 10, c); chk("acc_m2", 0, c);
    wr_reg(8'h18, 32'h80);
    repeat (2) @(posedge mclk_in);
    cnt(0, 10, c); chk("acc_m1", 10, c);
    ls_tick <= 1'b0;
    pin_b <= 1'b0;
    // external event on pin B counts in mode 00, refused in mode 01
    wr_reg(8'h14, 32'h12);
    wr_reg(8'h18, 32'ha8);
    repeat (4) @(posedge mclk_in);
    pin_b <= 1'b1;
    cnt(0, 8, c); chk("ext1", 1, c);
    pin_b <= 1'b0;
    repeat (4) @(posedge mclk_in);
    pin_b <= 1'b1;
    cnt(1, 8, c); chk("ext2", 1, c);
    pin_b <= 1'b0;
    wr_reg(8'h18, 32'ha9);
    repeat (4) @(posedge mclk_in);
    pin_b <= 1'b1;
    cnt(1, 8, c); chk("ext_m2", 0, c);
    pin_b <= 1'b0;
    $display("count sources done");
    // edge polarity per pin, and a disabled pin stays quiet
    for (int p = 0; p < 2; p++) begin
      for (int s = 0; s < 2; s++) begin
        wr_reg(8'h18, (p == 1) ? 32'h3c : 32'h30);
        repeat (6) @(posedge mclk_in);
        if (s == 0) pin_a <= 1'b1; else pin_b <= 1'b1;
        cnt(2 + s, 8, c); chk("rise", p, c);
        if (s == 0) pin_a <= 1'b0; else pin_b <= 1'b0;
        cnt(2 + s, 8, c); chk("fall", 1 - p, c);
      end
    end
    wr_reg(8'h18, 32'h0c);
    pin_a <= 1'b1;
    cnt(2, 8, c); chk("a_off", 0, c);
    pin_a <= 1'b0;
    $display("edges done");
    // pulse train select, software trigger and event flag
    wr_reg(8'h18, 32'h101);
    #1 chk("pt_m2", 1'b0, pt_act);
    wr_reg(8'h18, 32'h100);
    #1 chk("pt_act", 1'b1, pt_act);
    wr_reg(8'h18, 32'h300);
    cnt(4, 4, c); chk("pt_start", 1, c);
    wr_reg(8'h18, 32'h100);
    cnt(4, 4, c); chk("pt_zero", 0, c);
    @(posedge mclk_in);
    pt_ev <= 1'b1;
    @(posedge mclk_in);
    pt_ev <= 1'b0;
    rd_chk("pt_ev", 8'h18, 32'h400, 32'h400);
    wr_reg(8'h18, 32'h101);
    @(posedge mclk_in);
    pt_ev <= 1'b1;
    @(posedge mclk_in);
    pt_ev <= 1'b0;
    rd_chk("pt_ev_m2", 8'h18, 32'h400, 32'h0);
    $display("pulse train done");
    finish_test();
  end
endmodule
`default_nettype wire
